// *** hw/baud_clock_pkg.sv ***
// Package: register map, field positions, reset values and modes of the serial clock generator
package baud_clock_pkg;

	// ----------------------------------------------------------------
	// Register offsets (byte addresses, one word each)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_BAUD_DIV_CONTROL = 8'h00;
	localparam logic [7:0] OFS_BAUD_FRACTION_CONTROL = 8'h04;
	localparam logic [7:0] OFS_SERIAL_MODE_CTL0 = 8'h08;
	localparam logic [7:0] OFS_SERIAL_CTL_STATUS = 8'h0c;
	localparam logic [7:0] OFS_TIMER_COMPARE0 = 8'h10;
	localparam logic [7:0] OFS_CLOCK_STATUS = 8'h14;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int DIV_N_LSB = 0;
	localparam int INPUT_SEL_LSB = 4;
	localparam int FRAC_EN_BIT = 6;
	localparam int FRAC_K_LSB = 0;
	localparam int MODE_BIT = 0;
	localparam int UART_SRC_LSB = 1;
	localparam int SCLK_INPUT_BIT = 0;
	localparam int EDGE_FALL_BIT = 1;
	localparam int ST_SCLK_BIT = 0;
	localparam int ST_TIMER_BIT = 1;
	localparam int ST_RXBIT_BIT = 2;
	localparam int ST_RXCNT_LSB = 4;

	// ----------------------------------------------------------------
	// Reset values and counts
	// ----------------------------------------------------------------
	localparam logic [3:0] DIV_N_RST = 4'h0;
	localparam logic [1:0] INPUT_SEL_RST = 2'h0;
	localparam logic [3:0] FRAC_K_RST = 4'h0;
	localparam logic [3:0] FRAC_STEPS = 4'hf;
	localparam logic [3:0] UART_OVERSAMPLE_LAST = 4'hf;
	localparam logic [3:0] VOTE_FIRST = 4'h6;
	localparam logic [3:0] VOTE_SECOND = 4'h7;
	localparam logic [3:0] VOTE_LAST = 4'h8;

	// ----------------------------------------------------------------
	// Modes and selections
	// ----------------------------------------------------------------
	typedef enum logic {
		MODE_IO = 1'b0,
		MODE_UART = 1'b1
	} chan_mode_t;

	typedef enum logic [1:0] {
		SRC_TIMER = 2'b00,
		SRC_BAUD = 2'b01,
		SRC_SYSCLK = 2'b10,
		SRC_SCLK_IN = 2'b11
	} uart_src_t;

	typedef enum logic [1:0] {
		TAP_DIV2 = 2'b00,
		TAP_DIV8 = 2'b01,
		TAP_DIV32 = 2'b10,
		TAP_DIV128 = 2'b11
	} tap_sel_t;

endpackage : baud_clock_pkg

// *** hw/baud_rate_divider.sv ***
// Module: integer and fractional divider of the baud rate generator
`timescale 1ns/100ps
`default_nettype none

module baud_rate_divider #(
	parameter int DIV_W = 4
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic in_tick,
	input wire logic [DIV_W-1:0] div_n,
	input wire logic frac_en,
	input wire logic [3:0] frac_k,
	output logic out_tick
);
	import baud_clock_pkg::*;

	// Elaboration check: the fraction logic counts sixteenths of a 4-bit N
	if (DIV_W != 4) begin : g_div_w_check
		$error("baud_rate_divider: DIV_W must be 4");
	end

	typedef struct packed {
		logic [DIV_W:0] cnt;
		logic [3:0] phase;
		logic tick;
	} div_state_t;

	div_state_t st_ff;
	div_state_t nxt_st;
	logic [DIV_W:0] period;
	logic [4:0] stretch_limit;

	// ----------------------------------------------------------------
	// Divider
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.tick = 1'b0;
		// Zero in the N field stands for sixteen
		period = (div_n == '0) ? {1'b1, {DIV_W{1'b0}}} : {1'b0, div_n};
		// Phases below (16-K) of each sixteen periods take one more input clock
		stretch_limit = 5'd16 - {1'b0, frac_k};
		if (frac_en && ({1'b0, st_ff.phase} < stretch_limit)) begin
			period = period + 1'b1;
		end
		if (in_tick) begin
			if (st_ff.cnt + 1'b1 >= period) begin
				nxt_st.cnt = '0;
				nxt_st.tick = 1'b1;
				nxt_st.phase = (st_ff.phase == FRAC_STEPS) ? 4'h0 : st_ff.phase + 4'h1;
			end else begin
				nxt_st.cnt = st_ff.cnt + 1'b1;
			end
		end
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
		end else begin
			st_ff <= nxt_st;
		end
	end

	assign out_tick = st_ff.tick;

endmodule : baud_rate_divider

`default_nettype wire

// *** hw/serial_baud_clock_gen.sv ***
// Module: serial transfer clock generation with AHB-Lite register slave
//
// The implementer's own choices: the AHB-Lite register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none

// What this block does
// - The generator input is one of the div-2, div-8, div-32 or div-128 prescaler taps, with code 00 picking div-2.
// - In I/O interface mode the generator divides only by an integer N from 1 to 16.
// - In UART mode a select bit picks integer N or fractional N + (16-K)/16 division.
// - A mode bit picks UART or I/O interface, each with its own clock selection fields.
// - With the shift clock driven out, it is the generator output halved and transfers use its rising edge.
// - With the shift clock taken in, I/O mode transfers use its rising or falling edge as chosen; UART mode uses its rising edge only.
// - In UART mode the transfer clock is divided by sixteen in the bit counter.
// - The UART transfer clock comes from the timer, the generator, the system clock or the shift clock pin.
// - The timer flip-flop toggles on each compare match, so its period is twice the compare value.
// - The receiver samples at pulses seven, eight and nine and takes the majority.
module serial_baud_clock_gen #(
	parameter int TIMER_W = 16
) (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic prescale_tap_div2,
	input wire logic prescale_tap_div8,
	input wire logic prescale_tap_div32,
	input wire logic prescale_tap_div128,
	input wire logic timer_count_tick,
	input wire logic sclk_in,
	output logic sclk_out,
	output logic sclk_oe,
	input wire logic rxd,
	input wire logic bit_counter_clear,
	output logic transfer_clock,
	output logic bit_tick,
	output logic rx_bit,
	output logic rx_bit_valid
);
	import baud_clock_pkg::*;

	// Elaboration check: the compare value must fit one bus word
	if (TIMER_W < 2 || TIMER_W > 32) begin : g_timer_w_check
		$error("serial_baud_clock_gen: TIMER_W must be 2 to 32");
	end

	typedef struct packed {
		logic [3:0] div_n;
		tap_sel_t input_sel;
		logic frac_en;
		logic [3:0] frac_k;
		chan_mode_t mode;
		uart_src_t uart_src;
		logic sclk_input;
		logic edge_fall;
		logic [TIMER_W-1:0] cmp;
		logic wr_pend;
		logic [7:0] wr_addr;
		logic [31:0] rdata;
		logic ready;
		logic sclk_prev;
		logic [TIMER_W-1:0] tmr_cnt;
		logic tmr_ff;
		logic sclk_o;
		logic sclk_en;
		logic xfer;
		logic [3:0] rx_cnt;
		logic [1:0] votes;
		logic rbit;
		logic rbit_valid;
		logic btick;
	} gen_state_t;

	gen_state_t st_ff;
	gen_state_t nxt_st;
	logic baud_in_tick;
	logic baud_tick;
	logic sclk_rise;
	logic sclk_fall;
	logic tmr_rise;
	logic addr_phase;
	logic [2:0] vote_set;

	// ----------------------------------------------------------------
	// Baud rate generator
	// ----------------------------------------------------------------
	always_comb begin
		case (st_ff.input_sel)
			TAP_DIV2: baud_in_tick = prescale_tap_div2;
			TAP_DIV8: baud_in_tick = prescale_tap_div8;
			TAP_DIV32: baud_in_tick = prescale_tap_div32;
			TAP_DIV128: baud_in_tick = prescale_tap_div128;
			default: baud_in_tick = 1'b0;
		endcase
	end

	// Fraction only applies in UART mode; I/O mode is integer only
	baud_rate_divider #(
		.DIV_W(4)
	) u_divider (
		.mclk(mclk),
		.nrst(nrst),
		.in_tick(baud_in_tick),
		.div_n(st_ff.div_n),
		.frac_en(st_ff.frac_en && (st_ff.mode == MODE_UART)),
		.frac_k(st_ff.frac_k),
		.out_tick(baud_tick)
	);

	// ----------------------------------------------------------------
	// Register read mux
	// ----------------------------------------------------------------
	function automatic logic [31:0] read_word(input gen_state_t s, input logic [7:0] a);
		logic [31:0] w;
		w = 32'h0000_0000;
		case (a)
			OFS_BAUD_DIV_CONTROL: begin
				w[DIV_N_LSB +: 4] = s.div_n;
				w[INPUT_SEL_LSB +: 2] = s.input_sel;
				w[FRAC_EN_BIT] = s.frac_en;
			end
			OFS_BAUD_FRACTION_CONTROL: w[FRAC_K_LSB +: 4] = s.frac_k;
			OFS_SERIAL_MODE_CTL0: begin
				w[MODE_BIT] = s.mode;
				w[UART_SRC_LSB +: 2] = s.uart_src;
			end
			OFS_SERIAL_CTL_STATUS: begin
				w[SCLK_INPUT_BIT] = s.sclk_input;
				w[EDGE_FALL_BIT] = s.edge_fall;
			end
			OFS_TIMER_COMPARE0: w[TIMER_W-1:0] = s.cmp;
			OFS_CLOCK_STATUS: begin
				w[ST_SCLK_BIT] = s.sclk_o;
				w[ST_TIMER_BIT] = s.tmr_ff;
				w[ST_RXBIT_BIT] = s.rbit;
				w[ST_RXCNT_LSB +: 4] = s.rx_cnt;
			end
			default: w = 32'h0000_0000;
		endcase
		return w;
	endfunction : read_word

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		nxt_st.xfer = 1'b0;
		nxt_st.btick = 1'b0;
		nxt_st.rbit_valid = 1'b0;
		nxt_st.ready = 1'b1;
		sclk_rise = sclk_in && !st_ff.sclk_prev;
		sclk_fall = !sclk_in && st_ff.sclk_prev;
		tmr_rise = 1'b0;
		vote_set = 3'b000;
		nxt_st.sclk_prev = sclk_in;

		// Bus data phase: write lands here, before the read mux below sees it
		if (st_ff.wr_pend) begin
			case (st_ff.wr_addr)
				OFS_BAUD_DIV_CONTROL: begin
					nxt_st.div_n = hwdata[DIV_N_LSB +: 4];
					nxt_st.input_sel = tap_sel_t'(hwdata[INPUT_SEL_LSB +: 2]);
					nxt_st.frac_en = hwdata[FRAC_EN_BIT];
				end
				OFS_BAUD_FRACTION_CONTROL: nxt_st.frac_k = hwdata[FRAC_K_LSB +: 4];
				OFS_SERIAL_MODE_CTL0: begin
					nxt_st.mode = chan_mode_t'(hwdata[MODE_BIT]);
					nxt_st.uart_src = uart_src_t'(hwdata[UART_SRC_LSB +: 2]);
				end
				OFS_SERIAL_CTL_STATUS: begin
					nxt_st.sclk_input = hwdata[SCLK_INPUT_BIT];
					nxt_st.edge_fall = hwdata[EDGE_FALL_BIT];
				end
				OFS_TIMER_COMPARE0: nxt_st.cmp = hwdata[TIMER_W-1:0];
				default: nxt_st.div_n = st_ff.div_n;
			endcase
		end

		// Timer flip-flop: a half period of cmp count ticks, full period twice that
		if (timer_count_tick) begin
			if (st_ff.tmr_cnt == st_ff.cmp - 1'b1) begin
				nxt_st.tmr_cnt = '0;
				nxt_st.tmr_ff = !st_ff.tmr_ff;
				tmr_rise = !st_ff.tmr_ff;
			end else begin
				nxt_st.tmr_cnt = st_ff.tmr_cnt + 1'b1;
			end
		end

		// Transfer clock selection
		if (st_ff.mode == MODE_IO) begin
			if (st_ff.sclk_input) begin
				nxt_st.sclk_en = 1'b0;
				nxt_st.xfer = st_ff.edge_fall ? sclk_fall : sclk_rise;
			end else begin
				nxt_st.sclk_en = 1'b1;
				// Edge select is ignored here: output mode always uses the rising edge
				if (baud_tick) begin
					nxt_st.sclk_o = !st_ff.sclk_o;
					nxt_st.xfer = !st_ff.sclk_o;
				end
			end
			nxt_st.rx_cnt = 4'h0;
		end else begin
			nxt_st.sclk_en = 1'b0;
			nxt_st.sclk_o = 1'b1;
			case (st_ff.uart_src)
				SRC_TIMER: nxt_st.xfer = tmr_rise;
				SRC_BAUD: nxt_st.xfer = baud_tick;
				SRC_SYSCLK: nxt_st.xfer = 1'b1;
				SRC_SCLK_IN: nxt_st.xfer = sclk_rise;
				default: nxt_st.xfer = 1'b0;
			endcase
			// Sixteen transfer clocks per bit; vote on pulses seven to nine
			if (bit_counter_clear) begin
				nxt_st.rx_cnt = 4'h0;
			end else if (nxt_st.xfer) begin
				nxt_st.rx_cnt = st_ff.rx_cnt + 4'h1;
				nxt_st.btick = (st_ff.rx_cnt == UART_OVERSAMPLE_LAST);
				if (st_ff.rx_cnt == VOTE_FIRST) begin
					nxt_st.votes[0] = rxd;
				end
				if (st_ff.rx_cnt == VOTE_SECOND) begin
					nxt_st.votes[1] = rxd;
				end
				if (st_ff.rx_cnt == VOTE_LAST) begin
					vote_set = {rxd, st_ff.votes};
					nxt_st.rbit = (vote_set[0] & vote_set[1]) | (vote_set[0] & vote_set[2])
						| (vote_set[1] & vote_set[2]);
					nxt_st.rbit_valid = 1'b1;
				end
			end
		end

		// Bus address phase: zero wait states, always OKAY, unmapped reads give zero
		addr_phase = hsel && htrans[1] && hready;
		nxt_st.wr_pend = addr_phase && hwrite;
		nxt_st.wr_addr = haddr[7:0];
		nxt_st.rdata = (addr_phase && !hwrite) ? read_word(nxt_st, haddr[7:0]) : 32'h0000_0000;
	end

	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			st_ff <= '0;
			st_ff.div_n <= DIV_N_RST;
			st_ff.input_sel <= TAP_DIV2;
			st_ff.frac_k <= FRAC_K_RST;
			st_ff.mode <= MODE_IO;
			st_ff.uart_src <= SRC_TIMER;
			st_ff.ready <= 1'b1;
		end else begin
			st_ff <= nxt_st;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign hrdata = st_ff.rdata;
	assign hreadyout = st_ff.ready;
	assign hresp = 1'b0;
	assign sclk_out = st_ff.sclk_o;
	assign sclk_oe = st_ff.sclk_en;
	assign transfer_clock = st_ff.xfer;
	assign bit_tick = st_ff.btick;
	assign rx_bit = st_ff.rbit;
	assign rx_bit_valid = st_ff.rbit_valid;

endmodule : serial_baud_clock_gen

`default_nettype wire

// *** testbench/baud_clock_assertions.sv ***
// Checker: port-level timing rules of the serial clock generator
`timescale 1ns/100ps
`default_nettype none
module baud_clock_checker (
	input wire logic mclk,
	input wire logic nrst,
	input wire logic hsel,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic sclk_out,
	input wire logic sclk_oe,
	input wire logic bit_counter_clear,
	input wire logic transfer_clock,
	input wire logic bit_tick,
	input wire logic rx_bit,
	input wire logic rx_bit_valid
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!nrst);
	// ----
	// Pulses since the vote; a clear in mid-bit spoils the count
	// ----
	logic [4:0] cnt_ff;
	logic clean_ff;
	always_ff @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			cnt_ff <= 5'h0;
			clean_ff <= 1'b0;
		end else begin
			cnt_ff <= rx_bit_valid ? 5'h0 : cnt_ff + 5'(transfer_clock);
			clean_ff <= !bit_counter_clear && (clean_ff || rx_bit_valid);
		end
	end
	a_resp_okay: assert property (hresp == 1'b0) else $error("hresp not OKAY");
	a_ready_held: assert property ($past(hreadyout) |-> hreadyout) else $error("hreadyout dropped");
	a_rdata_idle: assert property (!$past(hsel && htrans[1] && !hwrite && hready) |-> hrdata == 32'h0)
		else $error("hrdata not zero outside read");
	a_io_no_bits: assert property (sclk_oe |-> !bit_tick && !rx_bit_valid) else $error("bit pulse in io mode");
	a_out_edge: assert property ($past(sclk_oe) && sclk_oe |-> transfer_clock == $rose(sclk_out))
		else $error("transfer clock not on shift clock rise");
	a_bit_length: assert property (bit_tick && clean_ff |-> cnt_ff == 5'd6) else $error("bit not 16 pulses");
	a_vote_pulse: assert property (bit_tick || rx_bit_valid |-> transfer_clock)
		else $error("bit pulse without transfer clock");
	a_bit_hold: assert property (!rx_bit_valid |-> $stable(rx_bit)) else $error("rx_bit moved without vote");
	a_single_pulse: assert property (bit_tick |=> !bit_tick && !rx_bit_valid) else $error("bit_tick too long");
endmodule : baud_clock_checker
bind serial_baud_clock_gen baud_clock_checker chk_u (.mclk(mclk), .nrst(nrst), .hsel(hsel), .htrans(htrans),
	.hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .sclk_out(sclk_out),
	.sclk_oe(sclk_oe), .bit_counter_clear(bit_counter_clear), .transfer_clock(transfer_clock), .bit_tick(bit_tick),
	.rx_bit(rx_bit), .rx_bit_valid(rx_bit_valid));
`default_nettype wire

// *** testbench/sclk_partner.sv ***
// Partner: outside device supplying the shift clock
`timescale 1ns/100ps
`default_nettype none
module sclk_partner (
	input wire logic mclk,
	input wire logic run,
	input wire logic [3:0] half,
	output logic sclk_in
);
	logic [3:0] cnt;
	initial begin
		sclk_in = 1'b1;
		cnt = 4'h0;
	end
	// Stands still outside frames; period is twice half, kept above the limits
	always @(posedge mclk) begin
		if (run && cnt + 4'h1 >= half) begin
			cnt <= 4'h0;
			sclk_in <= !sclk_in;
		end else if (run) begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule : sclk_partner
`default_nettype wire

// *** testbench/serial_baud_clock_gen_tb.sv ***
// Testbench: bus, divider, source and vote checks of the clock generator
`timescale 1ns/100ps
`default_nettype none
module serial_baud_clock_gen_tb;
	import baud_clock_pkg::*;
	logic mclk, nrst, hsel, hwrite, hreadyout, hresp, rxd, clr, run, rd_dp, rx_on, rx_exp, tmr_on;
	logic t2, t8, t32, t128, tmr, sclk_in, sclk_out, sclk_oe, tclk, btick, rxb, rxv;
	logic [31:0] haddr, hwdata, hrdata, r;
	logic [1:0] htrans;
	logic [3:0] half;
	logic [7:0] pre;
	logic [31:0] exp_q[$];
	int n_mismatch, n_compared, cyc, n;
	logic [7:0] ofs[6] = '{OFS_BAUD_DIV_CONTROL, OFS_BAUD_FRACTION_CONTROL, OFS_SERIAL_MODE_CTL0,
		OFS_SERIAL_CTL_STATUS, OFS_TIMER_COMPARE0, 8'h18};
	logic [31:0] msk[6] = '{32'h7f, 32'hf, 32'h7, 32'h3, 32'hffff, 32'h0};
	serial_baud_clock_gen #(.TIMER_W(16)) dut_u (.mclk(mclk), .nrst(nrst), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .prescale_tap_div2(t2), .prescale_tap_div8(t8),
		.prescale_tap_div32(t32), .prescale_tap_div128(t128), .timer_count_tick(tmr), .sclk_in(sclk_in),
		.sclk_out(sclk_out), .sclk_oe(sclk_oe), .rxd(rxd), .bit_counter_clear(clr), .transfer_clock(tclk),
		.bit_tick(btick), .rx_bit(rxb), .rx_bit_valid(rxv));
	sclk_partner far_u (.mclk(mclk), .run(run), .half(half), .sclk_in(sclk_in));
	task automatic final_report();
		if (n_mismatch == 0 && n_compared > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : final_report
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		n_compared++;
		if (s !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, s);
			n_mismatch++;
		end
	endtask : chk
	// ----
	// Bus master: address phase, then data phase, each until hready
	// ----
	task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		htrans <= 2'b10;
		hwrite <= w;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hsel <= 1'b0;
		hwdata <= d;
		rd_dp <= !w;
		if (!w) exp_q.push_back(d);
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd_dp <= 1'b0;
	endtask : xfer
	task automatic cfg(input logic [31:0] dv, input logic [31:0] fr, input logic [31:0] md, input logic [31:0] ct);
		xfer(OFS_BAUD_DIV_CONTROL, 1'b1, dv);
		xfer(OFS_BAUD_FRACTION_CONTROL, 1'b1, fr);
		xfer(OFS_SERIAL_MODE_CTL0, 1'b1, md);
		xfer(OFS_SERIAL_CTL_STATUS, 1'b1, ct);
	endtask : cfg
	// Cycles spanned by n transfer clock gaps, after two pulses to settle
	task automatic gap(input int n, input int e);
		int c, k;
		c = 0;
		k = 0;
		while (k < n + 2) begin
			@(posedge mclk);
			if (k >= 2) c++;
			if (tclk === 1'b1) k++;
		end
		chk("period", e, c);
	endtask : gap
	initial begin
		mclk = 1'b0;
		forever #12.5 mclk = !mclk;
	end
	always @(posedge mclk) begin
		pre <= pre + 8'h1;
		t2 <= pre[0] == 1'b0;
		t8 <= pre[2:0] == 3'h0;
		t32 <= pre[4:0] == 5'h0;
		t128 <= pre[6:0] == 7'h0;
		tmr <= tmr_on && pre[1:0] == 2'h0;
		cyc <= cyc + 1;
		if (cyc > 90000) begin
			n_mismatch++;
			final_report();
		end
		if (rd_dp === 1'b1) chk("hrdata", exp_q.pop_front(), hrdata);
		if (rx_on && rxv === 1'b1) chk("rx_bit", rx_exp, rxb);
	end
	initial begin
		{hsel, hwrite, rxd, clr, run, rd_dp, rx_on, rx_exp, t2, t8, t32, t128, tmr, tmr_on} = '0;
		{haddr, hwdata, htrans, half, pre, cyc, n_mismatch, n_compared} = '0;
		nrst = 1'b0;
		void'($urandom(32'hbc587d1c));
		repeat (6) @(posedge mclk);
		nrst <= 1'b1;
		repeat (2) @(posedge mclk);
		for (int i = 0; i < 6; i++) begin
			r = $urandom();
			if (i == 0 && r[3:0] == 4'h1) r[3:0] = 4'h2;
			xfer(ofs[i], 1'b0, 32'h0);
			xfer(ofs[i], 1'b1, r);
			xfer(ofs[i], 1'b0, r & msk[i]);
		end
		// I/O output: shift clock rises once per two generator pulses; N=16 is code 0
		for (int s = 0; s < 4; s++) begin
			n = (s == 0) ? 16 : (s == 3) ? 2 : 2 + $urandom() % 15;
			cfg(32'(n % 16) | 32'(s << 4), 0, 0, 0);
			gap(2, 4 * n * (2 << (2 * s)));
			chk("sclk_oe", 1, sclk_oe);
		end
		// UART fraction: any 16 periods hold 16N+16-K taps
		cfg(32'h42, 12, MODE_UART | (SRC_BAUD << 1), 0);
		gap(16, 2 * (16 * 2 + 4));
		xfer(OFS_TIMER_COMPARE0, 1'b1, 3);
		// Timer idle until now: a count left above a lowered compare would run to wrap-around
		tmr_on <= 1'b1;
		cfg(32'h42, 0, MODE_UART | (SRC_TIMER << 1), 0);
		gap(2, 2 * 2 * 3 * 4);
		half <= 4'd3;
		run <= 1'b1;
		cfg(32'h42, 0, MODE_UART | (SRC_SCLK_IN << 1), 0);
		gap(2, 12);
		half <= 4'd6;
		for (int e = 0; e < 2; e++) begin
			cfg(32'h42, 0, MODE_IO, 1 | (e << 1));
			gap(2, 24);
			@(posedge mclk iff tclk === 1'b1);
			chk("sclk_edge", !e, sclk_in);
			chk("sclk_oe", 0, sclk_oe);
		end
		run <= 1'b0;
		cfg(32'h42, 0, MODE_UART | (SRC_SYSCLK << 1), 0);
		gap(16, 16);
		rxd <= 1'b1;
		clr <= 1'b1;
		@(posedge mclk);
		clr <= 1'b0;
		@(posedge mclk iff rxv === 1'b1);
		rx_exp <= 1'b1;
		rx_on <= 1'b1;
		for (int b = 0; b < 8; b++) begin
			@(posedge mclk iff rxv === 1'b1);
			r = $urandom();
			rxd <= r[0];
			rx_exp <= r[0];
			// Spoil one of the three vote samples; the majority must still win
			repeat (12 + r[2:1] % 3) @(posedge mclk);
			rxd <= !r[0];
			@(posedge mclk);
			rxd <= r[0];
		end
		@(posedge mclk iff rxv === 1'b1);
		rx_on <= 1'b0;
		final_report();
	end
endmodule : serial_baud_clock_gen_tb
`default_nettype wire
